// *** inc/fmiu_cfg.svh ***
// Function
// [RULE1] Control register moves always transfer 32 bits
// [RULE2] Unimplemented control bits read zero, writes ignored
// [RULE3] Early variant: control move reports only protocol faults
// [RULE4] Exception byte writes never raise new exceptions
// [RULE5] Status changes only when it is destination
// [RULE6] Direction 0 loads register, 1 stores it
// [RULE7] Select 100 control, 010 status, 001 address
// [RULE8] Loads accept every mode, immediate included
// [RULE9] Address register direct only with instruction address
// [RULE10] Stores reject immediate and PC-relative modes
// [RULE11] Constant load rounds ROM value to precision
// [RULE12] Constant load sets codes, clears exception flags; code sets the inexact operation bit from rounding
// [RULE13] Offsets select pi, logs, e, zero
// [RULE14] Offsets 32 to 3F give powers of ten
// [RULE15] Undefined offsets return zero
// [RULE16] Execute only when coprocessor identifier matches
// [RULE17] Multiple move copies raw, status untouched
// [RULE18] Early variant: multiple move reports only protocol faults
// [RULE19] Eight bit mask selects data registers
// [RULE20] Dynamic mask uses low eight integer bits
// [RULE21] Control modes ascend addresses, registers 0 to 7
// [RULE22] Predecrement stores only, minus 12, 7 to 0
// [RULE23] Postincrement loads only, plus 12, 0 to 7
// [RULE24] Control move first and second word decode
// [RULE25] Constant load word decode with fixed pattern
`ifndef FMIU_CFG_SVH
`define FMIU_CFG_SVH
`define FMIU_OP_GEN 4'hF
`define FMIU_W1_CRMOVE 2'h2
`define FMIU_W1_MULTI 2'h3
`define FMIU_W1_CONST 6'h17
`define FMIU_SEL_CTRL 3'h4
`define FMIU_SEL_STAT 3'h2
`define FMIU_SEL_IAR 3'h1
`define FMIU_EA_DREG 3'h0
`define FMIU_EA_AREG 3'h1
`define FMIU_EA_POSTINC 3'h3
`define FMIU_EA_PREDEC 3'h4
`define FMIU_EA_EXT 3'h7
`define FMIU_EXT_ABSL 3'h1
`define FMIU_EXT_PCIDX 3'h3
`define FMIU_EXT_IMM 3'h4
`define FMIU_CTRL_MASK 32'h0000FFF0
`define FMIU_STAT_MASK 32'h0FFFFFF8
`define FMIU_IAR_MASK 32'hFFFFFFFF
`define FMIU_CTRL_RST 32'h00000000
`define FMIU_STAT_RST 32'h00000000
`define FMIU_IAR_RST 32'h00000000
`define FMIU_XREG_BYTES 8'h0C
`define FMIU_INEXACT_OP_BIT 9
`define FMIU_AINEX_BIT 3
`define FMIU_PREC_SGL 2'h1
`define FMIU_PREC_DBL 2'h2
`define FMIU_RND_RN 2'h0
`define FMIU_RND_RZ 2'h1
`define FMIU_RND_RM 2'h2
`define FMIU_LAST_IDX 3'h7
`endif

// *** inc/fmiu_pkg.sv ***
`default_nettype none
package fmiu_pkg;
	typedef enum logic [1:0] {
		FMIU_IDLE = 2'h0,
		FMIU_SCAN = 2'h1,
		FMIU_FETCH = 2'h2,
		FMIU_BEAT = 2'h3
	} fmiu_state_t;
	typedef logic [79:0] fmiu_xval_t;
endpackage
`default_nettype wire

// *** design/fmiu_const_rom.sv ***
`include "fmiu_cfg.svh"
`default_nettype none
module fmiu_const_rom import fmiu_pkg::*; (
	// Selection and rounding mode
	input wire logic [6:0] offset_i,
	input wire logic [1:0] prec_i,
	input wire logic [1:0] rnd_i,
	// Rounded constant
	output fmiu_xval_t val_o,
	output logic inexact_o
);
	fmiu_xval_t raw;
	logic [63:0] keep, half, ulp, rest;
	logic [64:0] sum;
	logic g, stk, lsbit, up;
	// [RULE13] [RULE14] [RULE15] constant table
	always_comb begin
		case (offset_i)
			7'h00: raw = 80'h4000C90FDAA22168C235;
			7'h0B: raw = 80'h3FFD9A209A84FBCFF798;
			7'h0C: raw = 80'h4000ADF85458A2BB4A9A;
			7'h0D: raw = 80'h3FFFB8AA3B295C17F0BC;
			7'h0E: raw = 80'h3FFDDE5BD8A937287195;
			7'h30: raw = 80'h3FFEB17217F7D1CF79AC;
			7'h31: raw = 80'h4000935D8DDDAAA8AC17;
			7'h32: raw = 80'h3FFF8000000000000000;
			7'h33: raw = 80'h4002A000000000000000;
			7'h34: raw = 80'h4005C800000000000000;
			7'h35: raw = 80'h400C9C40000000000000;
			7'h36: raw = 80'h4019BEBC200000000000;
			7'h37: raw = 80'h40348E1BC9BF04000000;
			7'h38: raw = 80'h40699DC5ADA82B70B59E;
			7'h39: raw = 80'h40D3C2781F49FFCFA6D5;
			7'h3A: raw = 80'h41A893BA47C980E98CE0;
			7'h3B: raw = 80'h4351AA7EEBFB9DF9DE8E;
			7'h3C: raw = 80'h46A3E319A0AEA60E91C7;
			7'h3D: raw = 80'h4D48C976758681750C17;
			7'h3E: raw = 80'h5A929E8B3B5DC53D5DE5;
			7'h3F: raw = 80'h7525C46052028A20979B;
			// Reserved offsets and 0F read as positive zero
			default: raw = 80'h00000000000000000000;
		endcase
	end
	// [RULE11] round mantissa to precision
	always_comb begin
		case (prec_i)
			`FMIU_PREC_SGL: begin
				keep = 64'hFFFFFF0000000000;
				half = 64'h0000008000000000;
				ulp = 64'h0000010000000000;
			end
			`FMIU_PREC_DBL: begin
				keep = 64'hFFFFFFFFFFFFF800;
				half = 64'h0000000000000400;
				ulp = 64'h0000000000000800;
			end
			default: begin
				keep = 64'hFFFFFFFFFFFFFFFF;
				half = 64'h0000000000000000;
				ulp = 64'h0000000000000000;
			end
		endcase
		rest = raw[63:0] & ~keep;
		inexact_o = |rest;
		g = |(rest & half);
		stk = |(rest & ~half);
		lsbit = |(raw[63:0] & ulp);
		case (rnd_i)
			`FMIU_RND_RN: up = g & (stk | lsbit);
			`FMIU_RND_RZ: up = 1'b0;
			`FMIU_RND_RM: up = inexact_o & raw[79];
			default: up = inexact_o & ~raw[79];
		endcase
		sum = {1'b0, raw[63:0] & keep} + (up ? {1'b0, ulp} : 65'h0);
		// Carry out renormalises to the next binade
		if (sum[64]) begin
			val_o = {raw[79], raw[78:64] + 15'h0001, 64'h8000000000000000};
		end else begin
			val_o = {raw[79:64], sum[63:0]};
		end
	end
endmodule // fmiu_const_rom
`default_nettype wire

// *** design/fmiu_top.sv ***
`include "fmiu_cfg.svh"
`default_nettype none
module fmiu_top import fmiu_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Instruction issue
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_word0_i,
	input wire logic [15:0] cmd_word1_i,
	output logic cmd_ready_o,
	output logic cmd_done_o,
	output logic cmd_illegal_o,
	// Configuration
	input wire logic [2:0] cop_id_i,
	input wire logic early_variant_i,
	// Effective address operands
	input wire logic [31:0] ea_rd_data_i,
	input wire logic [31:0] int_reg_i,
	output logic ea_wr_o,
	output logic [31:0] ea_wr_data_o,
	// Float data register file
	output logic [2:0] fpr_rd_idx_o,
	input wire fmiu_xval_t fpr_rd_data_i,
	output logic fpr_we_o,
	output logic [2:0] fpr_wr_idx_o,
	output fmiu_xval_t fpr_wr_data_o,
	// Multiple move beats
	output logic mm_valid_o,
	input wire logic mm_ready_i,
	output logic mm_store_o,
	output logic [7:0] mm_offset_o,
	output fmiu_xval_t mm_wdata_o,
	input wire fmiu_xval_t mm_rdata_i,
	// Exceptions
	input wire logic exc_pending_i,
	input wire logic proto_viol_i,
	output logic exc_report_o,
	// System control registers
	output logic [31:0] ctrl_reg_o,
	output logic [31:0] stat_reg_o,
	output logic [31:0] iar_o
);
	fmiu_state_t state_r;
	logic [2:0] idx_r;
	logic [7:0] mask_r, ofs_r;
	logic store_r, desc_r;
	logic [31:0] ctrl_r, stat_r, iar_r;
	logic ea_wr_r, fpr_we_r, done_r, ill_r, exc_r;
	logic [31:0] ea_wr_data_r;
	logic [2:0] fpr_wr_idx_r;
	fmiu_xval_t fpr_wr_data_r, mm_wdata_r;
	logic [2:0] ea_mode, ea_reg, sel, cur_reg;
	logic accept, id_ok, is_cr, is_const, is_mm, transfer_direction_bit, predec;
	logic sel_ok, cr_ea_ok, cr_ok, mm_ea_ok, mm_ok, last, bit_sel, finish, beat_go;
	logic [7:0] mask_in;
	logic [31:0] cr_rd;
	fmiu_xval_t rom_val;
	logic rom_inex, cc_z, cc_i, cc_nan;

	assign ea_mode = cmd_word0_i[5:3];
	assign ea_reg = cmd_word0_i[2:0];
	assign transfer_direction_bit = cmd_word1_i[13];
	assign sel = cmd_word1_i[12:10];
	assign predec = ~cmd_word1_i[12];
	assign accept = cmd_valid_i && (state_r == FMIU_IDLE);
	// [RULE16] identifier must match
	assign id_ok = (cmd_word0_i[15:12] == `FMIU_OP_GEN) && (cmd_word0_i[11:9] == cop_id_i);
	// [RULE24] control move word layout
	assign is_cr = id_ok && (cmd_word0_i[8:6] == 3'h0) && (cmd_word1_i[15:14] == `FMIU_W1_CRMOVE)
		&& (cmd_word1_i[9:0] == 10'h000);
	// [RULE25] constant load word layout
	assign is_const = id_ok && (cmd_word0_i[8:0] == 9'h000) && (cmd_word1_i[15:10] == `FMIU_W1_CONST);
	assign is_mm = id_ok && (cmd_word0_i[8:6] == 3'h0) && (cmd_word1_i[15:14] == `FMIU_W1_MULTI)
		&& (cmd_word1_i[10:8] == 3'h0);
	// [RULE7] one register per select code
	assign sel_ok = (sel == `FMIU_SEL_CTRL) || (sel == `FMIU_SEL_STAT) || (sel == `FMIU_SEL_IAR);
	always_comb begin
		case (ea_mode)
			// [RULE9] address direct only for address register
			`FMIU_EA_AREG: cr_ea_ok = (sel == `FMIU_SEL_IAR);
			// [RULE8] [RULE10] extension modes by direction
			`FMIU_EA_EXT: cr_ea_ok = transfer_direction_bit ? (ea_reg <= `FMIU_EXT_ABSL)
				: (ea_reg <= `FMIU_EXT_IMM);
			default: cr_ea_ok = 1'b1;
		endcase
	end
	assign cr_ok = is_cr && sel_ok && cr_ea_ok;
	always_comb begin
		case (ea_mode)
			`FMIU_EA_DREG: mm_ea_ok = 1'b0;
			`FMIU_EA_AREG: mm_ea_ok = 1'b0;
			// [RULE22] predecrement is store only
			`FMIU_EA_PREDEC: mm_ea_ok = transfer_direction_bit && predec;
			// [RULE23] postincrement is load only
			`FMIU_EA_POSTINC: mm_ea_ok = !transfer_direction_bit && !predec;
			`FMIU_EA_EXT: mm_ea_ok = !predec && (transfer_direction_bit ? (ea_reg <= `FMIU_EXT_ABSL)
				: (ea_reg <= `FMIU_EXT_PCIDX));
			default: mm_ea_ok = !predec;
		endcase
	end
	assign mm_ok = is_mm && mm_ea_ok;
	// [RULE20] dynamic list from low integer byte
	assign mask_in = cmd_word1_i[11] ? int_reg_i[7:0] : cmd_word1_i[7:0];
	always_comb begin
		case (sel)
			`FMIU_SEL_CTRL: cr_rd = ctrl_r;
			`FMIU_SEL_STAT: cr_rd = stat_r;
			default: cr_rd = iar_r;
		endcase
	end

	fmiu_const_rom u_rom (
		.offset_i(cmd_word1_i[6:0]),
		.prec_i(ctrl_r[7:6]),
		.rnd_i(ctrl_r[5:4]),
		.val_o(rom_val),
		.inexact_o(rom_inex)
	);
	assign cc_z = (rom_val[78:0] == 79'h0);
	assign cc_i = (rom_val[78:64] == 15'h7FFF) && (rom_val[62:0] == 63'h0);
	assign cc_nan = (rom_val[78:64] == 15'h7FFF) && (rom_val[62:0] != 63'h0);

	// [RULE21] [RULE22] register order by addressing mode, descending only for predecrement
	assign cur_reg = desc_r ? (`FMIU_LAST_IDX - idx_r) : idx_r;
	// [RULE19] mask bit per register, layout flips with order
	assign bit_sel = mask_r[`FMIU_LAST_IDX - idx_r];
	assign last = (idx_r == `FMIU_LAST_IDX);
	assign beat_go = (state_r == FMIU_BEAT) && mm_ready_i;
	assign finish = ((state_r == FMIU_SCAN) && !bit_sel && last) || (beat_go && last);

	// Multiple move sequencer
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_r <= FMIU_IDLE;
			idx_r <= 3'h0;
			mask_r <= 8'h00;
			ofs_r <= 8'h00;
			store_r <= 1'b0;
			desc_r <= 1'b0;
		end else begin
			case (state_r)
				FMIU_IDLE: begin
					if (accept && mm_ok) begin
						state_r <= FMIU_SCAN;
						idx_r <= 3'h0;
						mask_r <= mask_in;
						store_r <= transfer_direction_bit;
						desc_r <= (ea_mode == `FMIU_EA_PREDEC);
						// [RULE22] first store lands 12 below base
						ofs_r <= (ea_mode == `FMIU_EA_PREDEC) ? (8'h00 - `FMIU_XREG_BYTES) : 8'h00;
					end
				end
				FMIU_SCAN: begin
					if (bit_sel) begin
						state_r <= store_r ? FMIU_FETCH : FMIU_BEAT;
					end else if (last) begin
						state_r <= FMIU_IDLE;
					end else begin
						idx_r <= idx_r + 3'h1;
					end
				end
				FMIU_FETCH: state_r <= FMIU_BEAT;
				FMIU_BEAT: begin
					if (mm_ready_i) begin
						// [RULE21] [RULE22] [RULE23] step of one extended image
						ofs_r <= desc_r ? (ofs_r - `FMIU_XREG_BYTES) : (ofs_r + `FMIU_XREG_BYTES);
						if (last) begin
							state_r <= FMIU_IDLE;
						end else begin
							idx_r <= idx_r + 3'h1;
							state_r <= FMIU_SCAN;
						end
					end
				end
				default: state_r <= FMIU_IDLE;
			endcase
		end
	end

	// Store data is held stable for the whole beat
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mm_wdata_r <= 80'h00000000000000000000;
		end else if (state_r == FMIU_FETCH) begin
			// [RULE17] raw register image, no conversion
			mm_wdata_r <= fpr_rd_data_i;
		end
	end

	// System control registers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl_r <= `FMIU_CTRL_RST;
			stat_r <= `FMIU_STAT_RST;
			iar_r <= `FMIU_IAR_RST;
		end else if (accept && cr_ok && !transfer_direction_bit) begin
			// [RULE1] [RULE2] [RULE6] full word load, reserved bits dropped
			// [RULE4] no exception path from these writes
			case (sel)
				`FMIU_SEL_CTRL: ctrl_r <= ea_rd_data_i & `FMIU_CTRL_MASK;
				// [RULE5] status replaced only as destination
				`FMIU_SEL_STAT: stat_r <= ea_rd_data_i & `FMIU_STAT_MASK;
				default: iar_r <= ea_rd_data_i & `FMIU_IAR_MASK;
			endcase
		end else if (accept && is_const) begin
			// [RULE12] codes set, quotient kept, exceptions cleared except inexact, set from rounding
			stat_r[27:24] <= {1'b0, cc_z, cc_i, cc_nan};
			stat_r[15:8] <= 8'h00;
			stat_r[`FMIU_INEXACT_OP_BIT] <= rom_inex;
			stat_r[`FMIU_AINEX_BIT] <= stat_r[`FMIU_AINEX_BIT] | rom_inex;
		end
	end

	// Effective address write
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ea_wr_r <= 1'b0;
			ea_wr_data_r <= 32'h00000000;
		end else begin
			// [RULE6] direction 1 stores the register
			ea_wr_r <= accept && cr_ok && transfer_direction_bit;
			if (accept && cr_ok && transfer_direction_bit) begin
				// [RULE1] [RULE2] full word, reserved bits zero
				ea_wr_data_r <= cr_rd;
			end
		end
	end

	// Float register write port
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fpr_we_r <= 1'b0;
			fpr_wr_idx_r <= 3'h0;
			fpr_wr_data_r <= 80'h00000000000000000000;
		end else begin
			fpr_we_r <= (accept && is_const) || (beat_go && !store_r);
			if (accept && is_const) begin
				// [RULE11] rounded constant to destination
				fpr_wr_idx_r <= cmd_word1_i[9:7];
				fpr_wr_data_r <= rom_val;
			end else if (beat_go && !store_r) begin
				// [RULE17] loaded image written unchanged
				fpr_wr_idx_r <= cur_reg;
				fpr_wr_data_r <= mm_rdata_i;
			end
		end
	end

	// Completion and exception reporting
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			done_r <= 1'b0;
			ill_r <= 1'b0;
			exc_r <= 1'b0;
		end else begin
			done_r <= (accept && (cr_ok || is_const)) || finish;
			// Unknown operations for this identifier are refused, not dropped
			ill_r <= accept && id_ok && !(cr_ok || is_const || mm_ok);
			// [RULE3] [RULE18] early variant hides pending faults in moves
			exc_r <= proto_viol_i || (exc_pending_i && !(early_variant_i
				&& ((state_r != FMIU_IDLE) || (accept && (is_cr || is_mm)))));
		end
	end

	assign cmd_ready_o = (state_r == FMIU_IDLE);
	assign cmd_done_o = done_r;
	assign cmd_illegal_o = ill_r;
	assign ea_wr_o = ea_wr_r;
	assign ea_wr_data_o = ea_wr_data_r;
	assign fpr_rd_idx_o = cur_reg;
	assign fpr_we_o = fpr_we_r;
	assign fpr_wr_idx_o = fpr_wr_idx_r;
	assign fpr_wr_data_o = fpr_wr_data_r;
	assign mm_valid_o = (state_r == FMIU_BEAT);
	assign mm_store_o = store_r;
	assign mm_offset_o = ofs_r;
	assign mm_wdata_o = mm_wdata_r;
	assign exc_report_o = exc_r;
	assign ctrl_reg_o = ctrl_r;
	assign stat_reg_o = stat_r;
	assign iar_o = iar_r;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_reserved_zero: assert property ( // [RULE2]
		((ctrl_reg_o & ~`FMIU_CTRL_MASK) == 32'h0) && ((stat_reg_o & ~`FMIU_STAT_MASK) == 32'h0))
		else $error("reserved control bits set");
	a_ctrl_load: assert property ( // [RULE6]
		accept && cr_ok && !transfer_direction_bit && (sel == `FMIU_SEL_CTRL)
		|=> (ctrl_reg_o == ($past(ea_rd_data_i) & `FMIU_CTRL_MASK)) && cmd_done_o && !ea_wr_o)
		else $error("control load wrong");
	a_reg_store: assert property ( // [RULE1]
		accept && cr_ok && transfer_direction_bit |=> ea_wr_o && (ea_wr_data_o == $past(cr_rd)) && cmd_done_o)
		else $error("control store wrong");
	a_stat_only_dest: assert property ( // [RULE5]
		(stat_reg_o != $past(stat_reg_o))
		|-> $past(accept && ((cr_ok && !transfer_direction_bit && (sel == `FMIU_SEL_STAT)) || is_const)))
		else $error("status changed without cause");
	a_areg_refused: assert property ( // [RULE9]
		accept && is_cr && (ea_mode == `FMIU_EA_AREG) && (sel != `FMIU_SEL_IAR)
		|=> cmd_illegal_o && !cmd_done_o)
		else $error("address direct accepted");
	a_imm_store_bad: assert property ( // [RULE10]
		accept && is_cr && transfer_direction_bit && (ea_mode == `FMIU_EA_EXT) && (ea_reg == `FMIU_EXT_IMM)
		|=> cmd_illegal_o)
		else $error("immediate store accepted");
	a_imm_load_ok: assert property ( // [RULE8]
		accept && is_cr && sel_ok && !transfer_direction_bit
		&& (ea_mode == `FMIU_EA_EXT) && (ea_reg == `FMIU_EXT_IMM)
		|=> cmd_done_o && !cmd_illegal_o)
		else $error("immediate load refused");
	a_foreign_id: assert property ( // [RULE16]
		accept && (cmd_word0_i[11:9] != cop_id_i) |=> !cmd_done_o && !cmd_illegal_o && !fpr_we_o && !ea_wr_o)
		else $error("foreign instruction executed");
	a_const_flags: assert property ( // [RULE12]
		accept && is_const |=> fpr_we_o && (stat_reg_o[15:10] == 6'h00) && !stat_reg_o[8]
		&& (stat_reg_o[23:16] == $past(stat_reg_o[23:16])))
		else $error("constant flags wrong");
	a_early_quiet: assert property ( // [RULE18]
		early_variant_i && (state_r != FMIU_IDLE) && !proto_viol_i |=> !exc_report_o)
		else $error("pending fault reported in move");
	a_pre_step: assert property ( // [RULE22]
		beat_go && !last && desc_r |=> (mm_offset_o == $past(mm_offset_o) - `FMIU_XREG_BYTES))
		else $error("predecrement step wrong");
	a_post_step: assert property ( // [RULE23]
		beat_go && !last && !desc_r |=> (mm_offset_o == $past(mm_offset_o) + `FMIU_XREG_BYTES))
		else $error("postincrement step wrong");
	a_const_dest: assert property ( // [RULE11]
		accept && is_const |=> (fpr_wr_idx_o == $past(cmd_word1_i[9:7])) && cmd_done_o)
		else $error("constant destination wrong");
	a_dyn_mask: assert property ( // [RULE20]
		accept && mm_ok && cmd_word1_i[11] |=> (mask_r == $past(int_reg_i[7:0])))
		else $error("dynamic mask wrong");
	a_illegal_quiet: assert property ( // [RULE7]
		accept && id_ok && !(cr_ok || is_const || mm_ok) |=> !fpr_we_o && !ea_wr_o && cmd_ready_o
		&& (ctrl_reg_o == $past(ctrl_reg_o)) && (stat_reg_o == $past(stat_reg_o)))
		else $error("illegal operation changed state");
	a_raw_load: assert property ( // [RULE17]
		beat_go && !store_r |=> fpr_we_o && (fpr_wr_data_o == $past(mm_rdata_i)) && (stat_reg_o == $past(stat_reg_o)))
		else $error("multiple load altered data");

	c_ctrl_write: cover property (accept && cr_ok && !transfer_direction_bit && (sel == `FMIU_SEL_CTRL));
	c_early_hidden: cover property (early_variant_i && exc_pending_i && accept && cr_ok);
	c_const_inexact: cover property (accept && is_const && rom_inex);
	c_mm_store_done: cover property (desc_r && finish);
	c_mm_load_beat: cover property (beat_go && !store_r);
endmodule // fmiu_top
`default_nettype wire

// *** sim/fmiu_host_model.sv ***
`default_nettype none
module fmiu_host_model import fmiu_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Beat handshake
	input wire logic slow_i,
	input wire logic mm_valid_i,
	input wire logic [7:0] mm_offset_i,
	output logic mm_ready_o,
	output fmiu_xval_t mm_rdata_o,
	// Float register file
	input wire logic [2:0] fpr_rd_idx_i,
	output fmiu_xval_t fpr_rd_data_o,
	input wire logic fpr_we_i,
	input wire logic [2:0] fpr_wr_idx_i,
	input wire fmiu_xval_t fpr_wr_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	fmiu_xval_t fpr_r [8];
	fmiu_xval_t img;
	logic [1:0] wait_r;
	// Memory image tagged with its byte offset
	assign img = {8'h3F, mm_offset_i, 64'hC000_0000_0000_0000};
	// Outside a beat the bus shows the inverse so stale data cannot pass
	assign mm_rdata_o = mm_valid_i ? img : ~img;
	assign mm_ready_o = mm_valid_i && (!slow_i || wait_r == 2'h2);
	assign fpr_rd_data_o = fpr_r[fpr_rd_idx_i];
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !mm_valid_i || mm_ready_o) begin
			wait_r <= 2'h0;
		end else begin
			wait_r <= wait_r + 2'h1;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++) begin
				fpr_r[i] <= {8'h40, 5'h00, 3'(i), 64'h8000_0000_0000_0000};
			end
		end else if (fpr_we_i) begin
			fpr_r[fpr_wr_idx_i] <= fpr_wr_data_i;
		end
	end
endmodule // fmiu_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top import fmiu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_i, cmd_valid_i, cmd_ready_o, cmd_done_o, cmd_illegal_o, early_variant_i;
	logic ea_wr_o, fpr_we_o, mm_valid_o, mm_ready_i, mm_store_o, exc_pending_i, proto_viol_i, exc_report_o;
	logic slow, done_seen, il, ex;
	logic [15:0] cmd_word0_i, cmd_word1_i;
	logic [2:0] cop_id_i, fpr_rd_idx_o, fpr_wr_idx_o;
	logic [31:0] ea_rd_data_i, int_reg_i, ea_wr_data_o, ctrl_reg_o, stat_reg_o, iar_o, st;
	logic [7:0] mm_offset_o;
	fmiu_xval_t fpr_rd_data_i, fpr_wr_data_o, mm_wdata_o, mm_rdata_i;
	int errors, num_checks;
	logic [7:0] offs [$];
	fmiu_xval_t wds [$];
	localparam logic [15:0] IW0 [6] = '{16'hF208, 16'hF208, 16'hF23C, 16'hF23A, 16'hF200, 16'hF227};
	localparam logic [15:0] IW1 [6] = '{16'h9000, 16'h8400, 16'hB000, 16'hB000, 16'h8C00, 16'hC080};
	localparam logic [5:0] IIL = 6'b101111;
	localparam logic [6:0] CO [6] = '{7'h0F, 7'h01, 7'h32, 7'h33, 7'h34, 7'h00};
	localparam logic [79:0] CV [6] = '{80'h0, 80'h0, 80'h3FFF_8000_0000_0000_0000,
		80'h4002_A000_0000_0000_0000, 80'h4005_C800_0000_0000_0000, 80'h4000_C90F_DB00_0000_0000};
	localparam logic [31:0] CS [6] = '{32'h04FF_0000, 32'h04FF_0000, 32'h00FF_0000, 32'h00FF_0000,
		32'h00FF_0000, 32'h00FF_0208};
	localparam logic [31:0] RV [3] = '{32'h0000_FFF0, 32'h0FFF_FFF8, 32'hFFFF_FFFF};

	fmiu_top fmiu_top_inst (.core_clk_i, .rst_i, .cmd_valid_i, .cmd_word0_i, .cmd_word1_i, .cmd_ready_o,
		.cmd_done_o, .cmd_illegal_o, .cop_id_i, .early_variant_i, .ea_rd_data_i, .int_reg_i, .ea_wr_o,
		.ea_wr_data_o, .fpr_rd_idx_o, .fpr_rd_data_i, .fpr_we_o, .fpr_wr_idx_o, .fpr_wr_data_o, .mm_valid_o,
		.mm_ready_i, .mm_store_o, .mm_offset_o, .mm_wdata_o, .mm_rdata_i, .exc_pending_i, .proto_viol_i,
		.exc_report_o, .ctrl_reg_o, .stat_reg_o, .iar_o);
	fmiu_host_model fmiu_host_model_inst (.core_clk_i, .rst_i, .slow_i(slow), .mm_valid_i(mm_valid_o),
		.mm_offset_i(mm_offset_o), .mm_ready_o(mm_ready_i), .mm_rdata_o(mm_rdata_i),
		.fpr_rd_idx_i(fpr_rd_idx_o), .fpr_rd_data_o(fpr_rd_data_i), .fpr_we_i(fpr_we_o),
		.fpr_wr_idx_i(fpr_wr_idx_o), .fpr_wr_data_i(fpr_wr_data_o));

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (mm_valid_o === 1'b1 && mm_ready_i === 1'b1) begin
			offs.push_back(mm_offset_o);
			wds.push_back(mm_wdata_o);
		end
	end

	task automatic step();
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Issue one pair, then wait for its answer; a short limit means no answer is expected
	task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [31:0] ea, input int lim);
		int n;
		// One edge between pairs so valid is never dropped and raised in one step
		step();
		cmd_word0_i = w0;
		cmd_word1_i = w1;
		ea_rd_data_i = ea;
		cmd_valid_i = 1'b1;
		for (n = 0; n < lim && cmd_ready_o !== 1'b1; n++) step();
		step();
		cmd_valid_i = 1'b0;
		done_seen = 1'b0;
		il = 1'b0;
		ex = 1'b0;
		for (n = 0; n < lim && !done_seen && !il; n++) begin
			done_seen = cmd_done_o === 1'b1;
			il = cmd_illegal_o === 1'b1;
			ex = ex | (exc_report_o === 1'b1);
			if (!done_seen && !il) step();
		end
		if (!done_seen && !il && lim > 8) begin
			$display("unexpected at %0t: no answer", $time);
			errors++;
			tally_and_finish();
		end
	endtask

	initial begin
		#100000;
		$display("unexpected at %0t: run too long", $time);
		errors++;
		tally_and_finish();
	end

	initial begin
		{cmd_valid_i, cmd_word0_i, cmd_word1_i, early_variant_i, ea_rd_data_i, int_reg_i} = '0;
		{exc_pending_i, proto_viol_i, slow, errors, num_checks} = '0;
		cop_id_i = 3'h1;
		rst_i = 1'b1;
		repeat (12) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		chk({cmd_ready_o, ctrl_reg_o, stat_reg_o, iar_o}, {1'b1, 96'h0}, "reset state");
		run(16'hF23C, 16'h9000, 32'hFFFF_FFFF, 20);
		chk(ctrl_reg_o, RV[0], "control load");
		run(16'hF23C, 16'h8400, 32'hFFFF_FFFF, 20);
		chk({iar_o, stat_reg_o}, {RV[2], 32'h0}, "address load");
		run(16'hF23C, 16'h8800, 32'hFFFF_FFFF, 20);
		chk({ex, stat_reg_o}, {1'b0, RV[1]}, "status load");
		for (int i = 0; i < 3; i++) begin
			run(16'hF200, 16'hA000 | (16'h1000 >> i), 32'h0, 20);
			chk({done_seen, ea_wr_o, ea_wr_data_o}, {2'b11, RV[i]}, "register store");
		end
		$display("test control moves done");
		for (int i = 0; i < 6; i++) begin
			run(IW0[i], IW1[i], 32'h0, 20);
			chk({done_seen, il}, {!IIL[5 - i], IIL[5 - i]}, "mode legality");
		end
		run(16'hF43C, 16'h9000, 32'h0, 8);
		chk({done_seen, il, ctrl_reg_o}, {2'b00, RV[0]}, "foreign id");
		$display("test decode done");
		run(16'hF23C, 16'h9000, 32'h0, 20);
		run(16'hF23C, 16'h8800, 32'h00FF_FF00, 20);
		chk(ex, 1'b0, "exception byte write");
		for (int i = 0; i < 6; i++) begin
			if (i == 5) run(16'hF23C, 16'h9000, 32'h40, 20);
			run(16'hF200, 16'h5C00 | 16'(i << 7) | 16'(CO[i]), 32'h0, 20);
			chk({fpr_wr_idx_o, fpr_wr_data_o}, {3'(i), CV[i]}, "constant");
			chk({fpr_we_o, stat_reg_o}, {1'b1, CS[i]}, "constant status");
		end
		$display("test constants done");
		st = stat_reg_o;
		slow = 1'b1;
		run(16'hF227, 16'hE081, 32'h0, 200);
		chk({offs.size(), offs[0], offs[1], mm_store_o}, {32'h2, 16'hF4E8, 1'b1}, "store offsets");
		chk(wds[0], {8'h40, 8'h07, 64'h8000_0000_0000_0000}, "store reg7");
		chk(wds[1], 80'h0, "store reg0");
		slow = 1'b0;
		offs.delete();
		int_reg_i = 32'hFFFF_FF05;
		run(16'hF218, 16'hD820, 32'h0, 200);
		chk({offs.size(), offs[0], offs[1], mm_store_o}, {32'h2, 16'h000C, 1'b0}, "load offsets");
		// The last load lands in the register file one edge after done
		step();
		chk(fmiu_host_model_inst.fpr_r[5], {16'h3F00, 64'hC000_0000_0000_0000}, "load reg5");
		chk(fmiu_host_model_inst.fpr_r[7], {16'h3F0C, 64'hC000_0000_0000_0000}, "load reg7");
		chk(stat_reg_o, st, "status kept");
		$display("test multiple moves done");
		exc_pending_i = 1'b1;
		for (int k = 0; k < 4; k++) begin
			early_variant_i = k != 0;
			proto_viol_i = k == 2;
			if (k == 3) run(16'hF227, 16'hE000, 32'h0, 200);
			else run(16'hF200, 16'hB000, 32'h0, 20);
			chk(ex, k < 3 && k != 1, "pending report");
		end
		exc_pending_i = 1'b0;
		$display("test exceptions done");
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
